/* design/single_wire_master.v */
// Bus master for an open-drain single-wire link with identity and scratchpad layers
//
// Operation
// - Line rests high; the master releases it between all operations and pauses.
// - Any idle gap between bits is allowed; no timeout while line is high.
// - Access order: reset, identity command, memory command, then data.
// - Master sends reset pulse; slaves answer with a presence pulse.
// - After presence one eight-bit identity-layer command is sent.
// - Read identity only with a single slave attached.
// - After bypass with several slaves, issue no read-type memory command.
// - Pair 00 conflict, 01 all zero, 10 all one, 11 nobody answers.
// - Each search pass, started with reset, reveals one identity.
// - Scratchpad write 4Eh takes a page byte, then up to eight bytes.
// - A reset may end scratchpad writing after any byte.
`timescale 1ns/1ps
`default_nettype none
`include "single_wire_defs.vh"
module single_wire_master #(
	parameter [19:0] P_RESET_LOW   = `CYC_LEAST(`T_RESET_LOW_NS),
	parameter [19:0] P_PRES_SAMPLE = `CYC_MOST(`T_PRES_SAMPLE_NS),
	parameter [19:0] P_RESET_HIGH  = `CYC_LEAST(`T_RESET_HIGH_NS),
	parameter [19:0] P_SLOT        = `CYC_LEAST(`T_SLOT_NS),
	parameter [19:0] P_WR1_LOW     = `CYC_LEAST(`T_WR1_LOW_NS),
	parameter [19:0] P_WR0_LOW     = `CYC_LEAST(`T_WR0_LOW_NS),
	parameter [19:0] P_RD_LOW      = `CYC_LEAST(`T_RD_LOW_NS),
	parameter [19:0] P_RD_SAMPLE   = `CYC_MOST(`T_RD_SAMPLE_NS)
) (
	input  wire       i_mclk,
	input  wire       i_reset_n,
	input  wire       i_cmd_valid,
	output reg        o_cmd_ready,
	input  wire [1:0] i_cmd_op,
	input  wire [7:0] i_cmd_data,
	output wire       o_rd_valid,
	input  wire       i_rd_ready,
	output wire [7:0] o_rd_data,
	input  wire       i_line_in,
	output reg        o_line_out,
	output reg        o_line_oe,
	output reg        o_seq_err
);
	////////////////////////////////////////////////////////////////////////////
	// State and storage
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SLOT = 2'h1;
	localparam [1:0] ST_PUSH = 2'h2;

	reg  [1:0]  state_q;
	reg  [1:0]  op_q;
	reg  [7:0]  sh_q;
	reg  [2:0]  bit_q;
	reg  [1:0]  sub_q;
	reg  [2:0]  tri_q;
	reg         pick_q;
	reg  [19:0] timer_q;
	reg  [2:0]  phase_q;
	reg  [6:0]  cnt_q;
	reg         push_q;
	reg  [7:0]  push_data_q;
	wire        fifo_ready;

	reg  [19:0] low_len;
	reg  [19:0] samp_at;
	reg  [19:0] end_at;
	reg         wbit;
	reg         is_read;
	wire        accept;
	wire        slot_end;
	wire        last_bit;
	wire        dir;

	assign accept   = (state_q == ST_IDLE) && o_cmd_ready && i_cmd_valid;
	assign slot_end = (timer_q == end_at - 20'h0001);
	assign last_bit = (op_q == `OP_RESET) || ((op_q == `OP_TRIPLET) && (sub_q == 2'h2)) ||
		((op_q != `OP_TRIPLET) && (bit_q == 3'h7));
	// Search direction from the bit/complement pair
	assign dir = (tri_q[1:0] == 2'b00) ? pick_q : tri_q[0];

	////////////////////////////////////////////////////////////////////////////
	// Slot shape for the current bit
	always @* begin
		is_read = 1'b0;
		wbit    = 1'b1;
		low_len = P_RD_LOW;
		samp_at = P_RD_SAMPLE;
		end_at  = P_SLOT;
		case (op_q)
			`OP_RESET: begin
				// Low well beyond 480 us, then watch for presence
				low_len = P_RESET_LOW;
				samp_at = P_RESET_LOW + P_PRES_SAMPLE;
				end_at  = P_RESET_LOW + P_RESET_HIGH;
				is_read = 1'b1;
			end
			`OP_READ: begin
				is_read = 1'b1;
			end
			`OP_WRITE: begin
				wbit = sh_q[0];
			end
			`OP_TRIPLET: begin
				is_read = (sub_q != 2'h2);
				wbit    = dir;
			end
			default: begin
				is_read = 1'b0;
			end
		endcase
		if (!is_read) begin
			// One releases early, zero holds low for the slot
			low_len = wbit ? P_WR1_LOW : P_WR0_LOW;
			samp_at = P_SLOT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slot engine
	always @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_q     <= ST_IDLE;
			op_q        <= `OP_RESET;
			sh_q        <= 8'h00;
			bit_q       <= 3'h0;
			sub_q       <= 2'h0;
			tri_q       <= 3'h0;
			pick_q      <= 1'b0;
			timer_q     <= 20'h0_0000;
			push_q      <= 1'b0;
			push_data_q <= 8'h00;
			o_cmd_ready <= 1'b0;
			o_line_out  <= 1'b0;
			o_line_oe   <= 1'b0;
		end else begin
			o_line_out <= 1'b0;
			// Line released whenever no slot is active
			o_line_oe  <= (state_q == ST_SLOT) && (timer_q < low_len);
			case (state_q)
				ST_IDLE: begin
					o_cmd_ready <= 1'b1;
					if (accept) begin
						o_cmd_ready <= 1'b0;
						op_q        <= i_cmd_op;
						sh_q        <= i_cmd_data;
						pick_q      <= i_cmd_data[0];
						bit_q       <= 3'h0;
						sub_q       <= 2'h0;
						tri_q       <= 3'h0;
						timer_q     <= 20'h0_0000;
						state_q     <= ST_SLOT;
					end
				end
				ST_SLOT: begin
					timer_q <= timer_q + 20'h0_0001;
					if (is_read && (timer_q == samp_at)) begin
						if (op_q == `OP_RESET)
							sh_q <= {7'h00, ~i_line_in};
						else if (op_q == `OP_READ)
							sh_q <= {i_line_in, sh_q[7:1]};
						else if (sub_q == 2'h0)
							tri_q[0] <= i_line_in;
						else
							tri_q[1] <= i_line_in;
					end
					if (slot_end) begin
						timer_q <= 20'h0_0000;
						if (op_q == `OP_WRITE)
							sh_q <= {1'b1, sh_q[7:1]};
						if (op_q == `OP_TRIPLET && sub_q == 2'h1)
							tri_q[2] <= &tri_q[1:0] ? 1'b1 : 1'b0;
						if (last_bit) begin
							if (op_q == `OP_WRITE) begin
								state_q <= ST_IDLE;
							end else begin
								push_q      <= 1'b1;
								push_data_q <= (op_q == `OP_TRIPLET) ?
									{4'h0, tri_q[2], dir, tri_q[1:0]} : sh_q;
								state_q     <= ST_PUSH;
							end
						end else begin
							bit_q <= bit_q + 3'h1;
							sub_q <= sub_q + 2'h1;
						end
					end
				end
				ST_PUSH: begin
					// Waits here while the result buffer is full
					if (fifo_ready) begin
						push_q  <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transaction order tracking
	always @(posedge i_mclk) begin
		if (!i_reset_n) begin
			phase_q   <= `PH_NONE;
			cnt_q     <= 7'h00;
			o_seq_err <= 1'b0;
		end else if (accept) begin
			case (i_cmd_op)
				`OP_RESET: begin
					// Reset ends any transaction, scratchpad writes included
					phase_q   <= `PH_ROM;
					cnt_q     <= 7'h00;
					o_seq_err <= 1'b0;
				end
				`OP_WRITE: begin
					case (phase_q)
						`PH_ROM: begin
							cnt_q <= 7'h00;
							case (i_cmd_data)
								`CMD_SELECT:  phase_q <= `PH_ID;
								`CMD_BYPASS:  phase_q <= `PH_MEM;
								`CMD_SEARCH:  phase_q <= `PH_SEARCH;
								`CMD_READ_ID: phase_q <= `PH_IDREAD;
								default:      phase_q <= `PH_NONE;
							endcase
						end
						`PH_ID: begin
							cnt_q <= cnt_q + 7'h01;
							if (cnt_q == `ID_BYTES - 7'h01)
								phase_q <= `PH_MEM;
						end
						`PH_MEM: begin
							phase_q <= (i_cmd_data == `CMD_WRITE_SP) ? `PH_PAGE : `PH_NONE;
						end
						`PH_PAGE: begin
							if (i_cmd_data > `PAGE_MAX)
								o_seq_err <= 1'b1;
							cnt_q   <= 7'h00;
							phase_q <= `PH_DATA;
						end
						`PH_DATA: begin
							if (cnt_q == `SP_BYTES)
								o_seq_err <= 1'b1;
							else
								cnt_q <= cnt_q + 7'h01;
						end
						default: begin
							o_seq_err <= 1'b1;
						end
					endcase
				end
				`OP_READ: begin
					if (phase_q == `PH_IDREAD) begin
						cnt_q <= cnt_q + 7'h01;
						if (cnt_q == `ID_BYTES - 7'h01)
							phase_q <= `PH_MEM;
					end else if (phase_q == `PH_ROM || phase_q == `PH_PAGE ||
						phase_q == `PH_SEARCH) begin
						o_seq_err <= 1'b1;
					end
				end
				default: begin
					if (phase_q != `PH_SEARCH) begin
						o_seq_err <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 7'h01;
						if (cnt_q == `ID_BITS - 7'h01)
							phase_q <= `PH_MEM;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result buffer
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (4)
	) u_result_fifo (
		.i_mclk     (i_mclk),
		.i_reset_n  (i_reset_n),
		.i_wr_valid (push_q),
		.o_wr_ready (fifo_ready),
		.i_wr_data  (push_data_q),
		.o_rd_valid (o_rd_valid),
		.i_rd_ready (i_rd_ready),
		.o_rd_data  (o_rd_data)
	);
endmodule
`default_nettype wire

/* design/single_wire_defs.vh */
// Constants for the single-wire bus master: ops, commands, phases and slot times
`ifndef SINGLE_WIRE_DEFS_VH
`define SINGLE_WIRE_DEFS_VH

// Clock period and cycle conversion (least rounds up, longest rounds down)
`define CLK_PERIOD_NS       5
`define CYC_LEAST(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MOST(ns)       ((ns) / `CLK_PERIOD_NS)

// Slot times in ns
`define T_RESET_LOW_NS     500000
`define T_PRES_SAMPLE_NS   70000
`define T_RESET_HIGH_NS    480000
`define T_SLOT_NS          65000
`define T_WR1_LOW_NS       6000
`define T_WR0_LOW_NS       60000
`define T_RD_LOW_NS        6000
`define T_RD_SAMPLE_NS     15000

// User operations
`define OP_RESET           2'h0
`define OP_WRITE           2'h1
`define OP_READ            2'h2
`define OP_TRIPLET         2'h3

// Identity-layer and memory command codes
`define CMD_READ_ID        8'h33
`define CMD_SELECT         8'h55
`define CMD_BYPASS         8'hCC
`define CMD_SEARCH         8'hF0
`define CMD_WRITE_SP       8'h4E
`define PAGE_MAX           8'h07
`define SP_BYTES           7'h08
`define ID_BYTES           7'h08
`define ID_BITS            7'h40

// Transaction phases
`define PH_NONE            3'h0
`define PH_ROM             3'h1
`define PH_ID              3'h2
`define PH_IDREAD          3'h3
`define PH_SEARCH          3'h4
`define PH_MEM             3'h5
`define PH_PAGE            3'h6
`define PH_DATA            3'h7

`endif

/* design/byte_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4
) (
	input  wire             i_mclk,
	input  wire             i_reset_n,
	input  wire             i_wr_valid,
	output reg              o_wr_ready,
	input  wire [WIDTH-1:0] i_wr_data,
	output reg              o_rd_valid,
	input  wire             i_rd_ready,
	output reg  [WIDTH-1:0] o_rd_data
);
	localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam [AW:0] FULL_CNT = DEPTH;

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW-1:0]    rd_ptr_d;
	reg [AW:0]      count_q;
	reg [AW:0]      count_d;
	wire            do_wr;
	wire            do_rd;

	assign do_wr     = i_wr_valid && o_wr_ready;
	assign do_rd     = o_rd_valid && i_rd_ready;

	always @* begin
		count_d  = count_q;
		rd_ptr_d = rd_ptr_q;
		if (do_rd)
			rd_ptr_d = (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
		if (do_wr && !do_rd)
			count_d = count_q + 1'b1;
		else if (do_rd && !do_wr)
			count_d = count_q - 1'b1;
	end

	always @(posedge i_mclk) begin
		if (!i_reset_n) begin
			wr_ptr_q   <= {AW{1'b0}};
			rd_ptr_q   <= {AW{1'b0}};
			count_q    <= {(AW+1){1'b0}};
			o_wr_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data  <= {WIDTH{1'b0}};
		end else begin
			if (do_wr) begin
				mem_q[wr_ptr_q] <= i_wr_data;
				wr_ptr_q        <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			rd_ptr_q   <= rd_ptr_d;
			// Registered head word; a write into the head slot bypasses the array
			o_rd_data  <= (do_wr && (wr_ptr_q == rd_ptr_d)) ? i_wr_data : mem_q[rd_ptr_d];
			count_q    <= count_d;
			o_wr_ready <= (count_d != FULL_CNT);
			o_rd_valid <= (count_d != {(AW+1){1'b0}});
		end
	end
endmodule
`default_nettype wire

/* dv/single_wire_master_asserts.sv */
// Port checker for the single-wire bus master
`timescale 1ns/1ps
`default_nettype none
module single_wire_master_asserts #(
	parameter [19:0] P_RESET_LOW = 20'h0_0028,
	parameter [19:0] P_SLOT      = 20'h0_0014,
	parameter [19:0] P_WR1_LOW   = 20'h0_0002,
	parameter [19:0] P_WR0_LOW   = 20'h0_000C,
	parameter [19:0] P_RD_LOW    = 20'h0_0002
) (
	input wire logic       i_mclk,
	input wire logic       i_reset_n,
	input wire logic       i_cmd_valid,
	input wire logic       o_cmd_ready,
	input wire logic [1:0] i_cmd_op,
	input wire logic [7:0] i_cmd_data,
	input wire logic       o_rd_valid,
	input wire logic       i_rd_ready,
	input wire logic [7:0] o_rd_data,
	input wire logic       i_line_in,
	input wire logic       o_line_out,
	input wire logic       o_line_oe,
	input wire logic       o_seq_err
);
	logic [1:0]  op_q;
	logic [7:0]  dat_q;
	logic [19:0] low_q;
	logic [3:0]  idx_q;
	logic [31:0] busy_q;
	wire         fall = (low_q != 20'h0_0000) && !o_line_oe;
	always @(posedge i_mclk) begin
		if (!i_reset_n) begin
			op_q   <= 2'h0;
			dat_q  <= 8'h00;
			idx_q  <= 4'h0;
			busy_q <= 32'h0000_0000;
			low_q  <= 20'h0_0000;
		end else begin
			op_q   <= (i_cmd_valid && o_cmd_ready) ? i_cmd_op : op_q;
			dat_q  <= (i_cmd_valid && o_cmd_ready) ? i_cmd_data : dat_q;
			idx_q  <= (i_cmd_valid && o_cmd_ready) ? 4'h0 : idx_q + {3'h0, fall};
			busy_q <= (i_cmd_valid && o_cmd_ready) ? 32'h0000_0000 : busy_q + 32'h0000_0001;
			low_q  <= o_line_oe ? low_q + 20'h0_0001 : 20'h0_0000;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_drain_only: assert property (o_line_out == 1'b0)
		else $error("line driven high");
	a_idle_free: assert property (o_cmd_ready |-> !o_line_oe)
		else $error("line held while idle");
	a_reset_len: assert property ((fall && op_q == 2'h0) |-> low_q == P_RESET_LOW)
		else $error("reset pulse length wrong");
	a_write_bits: assert property ((fall && op_q == 2'h1) |->
		low_q == (dat_q[idx_q[2:0]] ? P_WR1_LOW : P_WR0_LOW)) else $error("write bit wrong");
	a_read_low: assert property ((fall && op_q == 2'h2) |-> low_q == P_RD_LOW)
		else $error("read slot length wrong");
	a_trip_reads: assert property ((fall && op_q == 2'h3 && idx_q < 4'h2) |-> low_q == P_RD_LOW)
		else $error("triplet read slot wrong");
	a_take_drop: assert property ((i_cmd_valid && o_cmd_ready) |=> !o_cmd_ready)
		else $error("ready held after take");
	a_write_busy: assert property (($rose(o_cmd_ready) && op_q == 2'h1) |-> busy_q >= 8 * P_SLOT)
		else $error("write ended early");
	a_result_hold: assert property ((o_rd_valid && !i_rd_ready) |=> o_rd_valid && $stable(o_rd_data))
		else $error("result dropped");
	a_err_clear: assert property ((i_cmd_valid && o_cmd_ready && i_cmd_op == 2'h0) |-> ##[1:100] !o_seq_err)
		else $error("order error not cleared");
endmodule
bind single_wire_master single_wire_master_asserts #(.P_RESET_LOW(P_RESET_LOW), .P_SLOT(P_SLOT),
	.P_WR1_LOW(P_WR1_LOW), .P_WR0_LOW(P_WR0_LOW), .P_RD_LOW(P_RD_LOW)) u_chk (.i_mclk(i_mclk),
	.i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op),
	.i_cmd_data(i_cmd_data), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data),
	.i_line_in(i_line_in), .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_seq_err(o_seq_err));
`default_nettype wire

/* dv/single_wire_slave_model.sv */
// Behavioural slave device on the shared line
`timescale 1ns/1ps
`default_nettype none
module single_wire_slave_model #(
	parameter [63:0] ID = 64'hC3A5_6B0F_7788_9942 // Arbitrary identity value
) (
	input  wire logic i_mclk,
	input  wire logic i_line,
	output var  logic o_pull
);
	logic [7:0] sp [0:63];
	logic       rst;
	logic       b;
	logic [7:0] v;
	logic [7:0] pg;
	task automatic slot(input logic tx);
		int n;
		n = 0;
		while (i_line !== 1'b0) @(posedge i_mclk);
		o_pull <= !tx;
		repeat (6) @(posedge i_mclk);
		b = i_line;
		o_pull <= 1'b0;
		while (i_line === 1'b0 && n < 60) begin
			n++;
			@(posedge i_mclk);
		end
		rst = n > 12;
		if (rst) begin
			repeat (2) @(posedge i_mclk);
			o_pull <= 1'b1;
			repeat (14) @(posedge i_mclk);
			o_pull <= 1'b0;
			@(posedge i_mclk);
		end
	endtask
	task automatic get_byte();
		for (int i = 0; i < 8; i++) begin
			if (!rst) slot(1'b1);
			v[i] = b;
		end
	endtask
	task automatic run();
		get_byte();
		if (rst) return;
		if (v == 8'h33) begin
			for (int i = 0; i < 64 && !rst; i++) slot(ID[i]);
		end else if (v == 8'h55) begin
			for (int i = 0; i < 64 && !rst; i++) begin
				slot(1'b1);
				if (b !== ID[i]) return;
			end
		end else if (v == 8'hF0) begin
			for (int i = 0; i < 64 && !rst; i++) begin
				slot(ID[i]);
				slot(!ID[i]);
				slot(1'b1);
				if (b !== ID[i]) return;
			end
		end else if (v != 8'hCC) return;
		get_byte();
		if (rst || v != 8'h4E) return;
		get_byte();
		pg = v;
		if (rst || pg > 8'h07) return;
		for (int k = 0; k < 8; k++) begin
			get_byte();
			if (rst) return;
			sp[pg * 8 + k] = v;
		end
	endtask
	initial begin
		o_pull = 1'b0;
		rst = 1'b0;
		for (int i = 0; i < 64; i++) sp[i] = 8'h00;
		forever begin
			while (!rst) slot(1'b1);
			rst = 1'b0;
			run();
		end
	end
endmodule
`default_nettype wire

/* dv/single_wire_master_bench.sv */
// Self-checking bench for the single-wire master against two device models
`timescale 1ns/1ps
`default_nettype none
module single_wire_master_bench;
	localparam logic [63:0] DEV_ID = 64'hC3A5_6B0F_7788_9942; // Arbitrary identity value
	localparam logic [63:0] DEV2_ID = DEV_ID ^ 64'h0000_0000_0000_0100; // Differs in bit 8 only
	localparam logic [19:0] RST_LOW  = 20'h0_0028;
	localparam logic [19:0] PRES_AT  = 20'h0_000A;
	localparam logic [19:0] RST_HIGH = 20'h0_0020;
	localparam logic [19:0] SLOT_LEN = 20'h0_0014;
	localparam logic [19:0] WR1_LOW  = 20'h0_0002;
	localparam logic [19:0] WR0_LOW  = 20'h0_000C;
	localparam logic [19:0] RD_LOW   = 20'h0_0002;
	localparam logic [19:0] RD_AT    = 20'h0_0005;
	logic       i_mclk;
	logic       i_reset_n;
	logic       i_cmd_valid;
	logic [1:0] i_cmd_op;
	logic [7:0] i_cmd_data;
	logic       i_rd_ready;
	wire        o_cmd_ready;
	wire        o_rd_valid;
	wire  [7:0] o_rd_data;
	wire        o_line_oe;
	wire        o_seq_err;
	wire        line_out;
	wire        pull;
	wire        pull2;
	logic       two_dev;
	wire        line = !((o_line_oe && !line_out) || pull || (pull2 && two_dev));
	int         error_cnt = 0;
	int         checked = 0;
	logic [7:0] r;
	single_wire_master #(.P_RESET_LOW(RST_LOW), .P_PRES_SAMPLE(PRES_AT),
		.P_RESET_HIGH(RST_HIGH), .P_SLOT(SLOT_LEN), .P_WR1_LOW(WR1_LOW),
		.P_WR0_LOW(WR0_LOW), .P_RD_LOW(RD_LOW), .P_RD_SAMPLE(RD_AT)) i_dut (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid),
		.o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_data(i_cmd_data),
		.o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data),
		.i_line_in(line), .o_line_out(line_out), .o_line_oe(o_line_oe), .o_seq_err(o_seq_err));
	single_wire_slave_model #(.ID(DEV_ID)) dev (.i_mclk(i_mclk), .i_line(line), .o_pull(pull));
	single_wire_slave_model #(.ID(DEV2_ID)) dev2 (.i_mclk(i_mclk), .i_line(line), .o_pull(pull2));
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d, errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_cmd_ready !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic op(input logic [1:0] o, input logic [7:0] d);
		@(posedge i_mclk);
		i_cmd_op <= o;
		i_cmd_data <= d;
		i_cmd_valid <= 1'b1;
		wait_ready();
		i_cmd_valid <= 1'b0;
	endtask
	task automatic take(output logic [7:0] v);
		int n;
		n = 0;
		@(negedge i_mclk);
		while (o_rd_valid !== 1'b1 && n < 4000) begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 4000) begin
			error_cnt++;
			give_verdict();
		end
		v = o_rd_data;
		@(posedge i_mclk);
		i_rd_ready <= 1'b1;
		@(posedge i_mclk);
		i_rd_ready <= 1'b0;
	endtask
	task automatic init();
		op(2'h0, 8'h00);
		take(r);
		check(r & 8'h01, 8'h01);
		check({7'h00, o_seq_err}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_bypass_write();
		init();
		op(2'h1, 8'hCC);
		op(2'h1, 8'h4E);
		op(2'h1, 8'h03);
		for (int k = 0; k < 8; k++) op(2'h1, 8'hA0 + k[7:0]);
		op(2'h1, 8'h77);
		wait_ready();
		check({7'h00, o_seq_err}, 8'h01);
		init();
		for (int k = 0; k < 8; k++) check(dev.sp[24 + k], 8'hA0 + k[7:0]);
		op(2'h1, 8'hCC);
		op(2'h1, 8'h4E);
		op(2'h1, 8'h04);
		op(2'h1, 8'h11);
		init();
	endtask
	task automatic s_read_id();
		init();
		op(2'h1, 8'h33);
		for (int i = 0; i < 5; i++) op(2'h2, 8'h00);
		for (int i = 0; i < 5; i++) begin
			take(r);
			check(r, DEV_ID[8 * i +: 8]);
		end
		for (int i = 5; i < 8; i++) begin
			op(2'h2, 8'h00);
			take(r);
			check(r, DEV_ID[8 * i +: 8]);
		end
	endtask
	task automatic s_select();
		for (int p = 0; p < 2; p++) begin
			init();
			op(2'h1, 8'h55);
			for (int i = 0; i < 8; i++) op(2'h1, DEV_ID[8 * i +: 8] ^ {i == 7 && p == 0, 7'h00});
			op(2'h1, 8'h4E);
			op(2'h1, 8'h01);
			op(2'h1, 8'h5C);
			init();
			check(dev.sp[8], p == 0 ? 8'h00 : 8'h5C);
		end
	endtask
	task automatic s_search();
		logic [7:0] e;
		two_dev <= 1'b1;
		init();
		op(2'h1, 8'hF0);
		for (int i = 0; i < 64; i++) begin
			op(2'h3, 8'h01);
			take(r);
			// Bit 8 conflicts: pair 00, preferred direction 1 keeps the first device
			e = (i == 8) ? 8'h04 : {5'h00, DEV_ID[i], !DEV_ID[i], DEV_ID[i]};
			check(r & 8'h0F, e);
		end
		two_dev <= 1'b0;
	endtask
	task automatic s_errors();
		init();
		op(2'h3, 8'h00);
		take(r);
		check(r, 8'h0F);
		check({7'h00, o_seq_err}, 8'h01);
		init();
		op(2'h1, 8'h5A);
		op(2'h1, 8'h00);
		wait_ready();
		check({7'h00, o_seq_err}, 8'h01);
		init();
		op(2'h1, 8'hCC);
		op(2'h1, 8'h4E);
		op(2'h1, 8'h08);
		wait_ready();
		check({7'h00, o_seq_err}, 8'h01);
		init();
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = !i_mclk;
	end
	initial begin
		i_reset_n = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd_op = 2'h0;
		i_cmd_data = 8'h00;
		i_rd_ready = 1'b0;
		two_dev = 1'b0;
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		s_bypass_write();
		s_read_id();
		s_select();
		s_search();
		s_errors();
		give_verdict();
	end
endmodule
`default_nettype wire
